// ---- hdl/tfm_regs.sv ----
/*
  Thermal control / fault mask register bank with its I2C slave, interrupt
  gating and fault deglitch timing. Assumes scl and sda come from pins and
  all analog event inputs are asynchronous; sda is open drain.
*/
`timescale 1ns/100ps
module tfm_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h2A, // Arbitrary bus address
  parameter int DEGLITCH_CYCLES = 1000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // I2C pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Analog and system events
  input wire logic [1:0] temp_zone_in,
  input wire logic input_supply,
  input wire logic battery_powered_mode,
  input wire logic fault_raw,
  input wire logic wake_event,
  input wire logic push_button_in,
  input wire logic timer_fault,
  input wire logic other_fault,
  input wire logic charge_status,
  // Control outputs
  output logic temp_sense_enable,
  output logic charge_suspend,
  output logic charge_half_current,
  output logic charge_volt_drop,
  output logic high_impedance_mode,
  output logic [7:0] fast_charge_ctrl_out,
  output logic deglitch_clk_en,
  output logic fault_deglitched,
  output logic reset_out,
  output logic int_out
);
  import tfm_pkg::*;

  if (DEGLITCH_CYCLES < 1 || DEGLITCH_CYCLES > 65535) begin : g_bad_deglitch
    $error("DEGLITCH_CYCLES out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [TFM_NSYNC-1:0] raw_in;
  logic [TFM_NSYNC-1:0] sync1;
  logic [TFM_NSYNC-1:0] sync2;
  logic scl_d;
  logic sda_d;

  assign raw_in = {charge_status, other_fault, timer_fault, push_button_in, wake_event,
                   fault_raw, battery_powered_mode, input_supply, temp_zone_in,
                   sda_in, scl_in};

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1 <= TFM_SYNC_RST;
      sync2 <= TFM_SYNC_RST;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
      scl_d <= sync2[0];
      sda_d <= sync2[1];
    end
  end

  logic scl_s, sda_s;
  logic [1:0] zone_s;
  logic supply_s, bat_s, fault_s, wake_s, pb_s, timer_s, other_s, chg_s;
  assign {chg_s, other_s, timer_s, pb_s, wake_s, fault_s, bat_s, supply_s, zone_s,
          sda_s, scl_s} = sync2;

  logic start_c, stop_c, rise_c, fall_c;
  assign start_c = scl_s & sda_d & ~sda_s;
  assign stop_c = scl_s & ~sda_d & sda_s;
  assign rise_c = scl_s & ~scl_d;
  assign fall_c = ~scl_s & scl_d;

  ////////////////////////////////////////////////////////////////////////////
  // Register read decode
  logic [7:0] therm_reg;
  logic [7:0] fchg_reg;

  function automatic logic [7:0] rd_reg(input logic [7:0] ofs, input logic [7:0] th,
                                        input logic [7:0] fc, input logic [1:0] zn);
    logic [7:0] v;
    v = 8'h00;
    if (ofs == TFM_THERM_OFS) begin
      // Live zone, masks do not hide it
      v = th & TFM_THERM_WMASK;
      v[TFM_ZONE_HI_BIT] = zn[1];
      v[TFM_ZONE_LO_BIT] = zn[0];
    end else if (ofs == TFM_FCHG_OFS) begin
      v = fc;
    end
    return v;
  endfunction

  // Zone reads normal while sensing is off
  logic [1:0] zone_eff;
  assign zone_eff = therm_reg[TFM_TEMP_EN_BIT] ? zone_s : TFM_ZONE_NORMAL;

  ////////////////////////////////////////////////////////////////////////////
  // I2C slave and register writes
  tfm_state_t state, next_state;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [7:0] shreg, next_shreg;
  logic [7:0] ptr, next_ptr;
  logic rw, next_rw;
  logic done8, next_done8;
  logic ptr_done, next_ptr_done;
  logic oe, next_oe;
  logic [7:0] next_therm, next_fchg;
  logic [7:0] rd_now;

  assign rd_now = rd_reg(ptr, therm_reg, fchg_reg, zone_eff);

  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_ptr = ptr;
    next_rw = rw;
    next_done8 = done8;
    next_ptr_done = ptr_done;
    next_oe = oe;
    next_therm = therm_reg;
    next_fchg = fchg_reg;
    if (stop_c) begin
      next_state = TFM_IDLE;
      next_oe = 1'b0;
    end else if (start_c) begin
      next_state = TFM_ADDR;
      next_bit_cnt = 3'h0;
      next_done8 = 1'b0;
      next_ptr_done = 1'b0;
      next_oe = 1'b0;
    end else begin
      unique case (state)
        TFM_IDLE: begin
          next_oe = 1'b0;
        end
        TFM_ADDR, TFM_PTR, TFM_WDATA: begin
          if (rise_c) begin
            next_shreg = {shreg[6:0], sda_s};
            next_bit_cnt = bit_cnt + 3'h1;
            next_done8 = (bit_cnt == 3'h7);
          end else if (fall_c && done8) begin
            next_done8 = 1'b0;
            next_oe = 1'b1;
            next_state = TFM_ACK;
            if (state == TFM_ADDR) begin
              next_rw = shreg[0];
              if (shreg[7:1] != DEV_ADDR) begin
                next_oe = 1'b0;
                next_state = TFM_IDLE;
              end
            end else if (state == TFM_PTR) begin
              next_ptr = shreg;
              next_ptr_done = 1'b1;
            end else begin
              if (ptr == TFM_THERM_OFS) begin
                next_therm = shreg & TFM_THERM_WMASK;
              end else if (ptr == TFM_FCHG_OFS) begin
                next_fchg = shreg;
              end
              next_ptr = ptr + 8'h01;
            end
          end
        end
        TFM_ACK: begin
          if (fall_c) begin
            next_oe = 1'b0;
            next_bit_cnt = 3'h0;
            if (rw) begin
              next_shreg = rd_now;
              next_oe = ~rd_now[7];
              next_ptr = ptr + 8'h01;
              next_state = TFM_READ;
            end else begin
              next_state = ptr_done ? TFM_WDATA : TFM_PTR;
            end
          end
        end
        TFM_READ: begin
          if (fall_c) begin
            if (bit_cnt == 3'h7) begin
              next_oe = 1'b0;
              next_state = TFM_MACK;
              next_done8 = 1'b0;
            end else begin
              next_shreg = {shreg[6:0], 1'b0};
              next_oe = ~shreg[6];
              next_bit_cnt = bit_cnt + 3'h1;
            end
          end
        end
        TFM_MACK: begin
          if (rise_c) begin
            if (sda_s) begin
              next_state = TFM_IDLE;
            end else begin
              next_done8 = 1'b1;
            end
          end else if (fall_c && done8) begin
            next_done8 = 1'b0;
            next_bit_cnt = 3'h0;
            next_shreg = rd_now;
            next_oe = ~rd_now[7];
            next_ptr = ptr + 8'h01;
            next_state = TFM_READ;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= TFM_IDLE;
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      rw <= 1'b0;
      done8 <= 1'b0;
      ptr_done <= 1'b0;
      oe <= 1'b0;
      therm_reg <= TFM_THERM_RST;
      fchg_reg <= TFM_FCHG_RST;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      ptr <= next_ptr;
      rw <= next_rw;
      done8 <= next_done8;
      ptr_done <= next_ptr_done;
      oe <= next_oe;
      therm_reg <= next_therm;
      fchg_reg <= next_fchg;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = oe;

  ////////////////////////////////////////////////////////////////////////////
  // Fault deglitch
  // Counting needs the deglitch clock; a fault with no bus and no supply holds
  logic i2c_busy;
  logic dg_run;
  logic [15:0] dg_cnt, next_dg_cnt;
  logic flt, next_flt;

  assign i2c_busy = (state != TFM_IDLE);
  assign deglitch_clk_en = ~fchg_reg[TFM_HIGH_IMP_BIT];
  assign dg_run = deglitch_clk_en & (supply_s | (bat_s & i2c_busy));

  always_comb begin
    next_dg_cnt = dg_cnt;
    next_flt = flt;
    if (fault_s) begin
      // Fresh fault wins over a clear in the same cycle
      next_flt = 1'b1;
      next_dg_cnt = 16'h0000;
    end else if (flt && dg_run) begin
      if (dg_cnt == 16'(DEGLITCH_CYCLES - 1)) begin
        next_flt = 1'b0;
        next_dg_cnt = 16'h0000;
      end else begin
        next_dg_cnt = dg_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dg_cnt <= 16'h0000;
      flt <= 1'b0;
    end else begin
      dg_cnt <= next_dg_cnt;
      flt <= next_flt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt gating and control outputs
  logic next_int, next_rst_out;
  logic next_susp, next_half, next_drop;

  always_comb begin
    next_int = other_s | flt
      | (chg_s & therm_reg[TFM_INT_EN_BIT])
      | (wake_s & ~therm_reg[TFM_WAKE_M_BIT])
      | (pb_s & ~therm_reg[TFM_RESET_M_BIT])
      | (timer_s & ~therm_reg[TFM_TIMER_M_BIT]);
    next_rst_out = pb_s;
    next_susp = (zone_eff == TFM_ZONE_SUSPEND);
    next_half = (zone_eff == TFM_ZONE_HALF);
    next_drop = (zone_eff == TFM_ZONE_WARM);
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      int_out <= 1'b0;
      reset_out <= 1'b0;
      charge_suspend <= 1'b0;
      charge_half_current <= 1'b0;
      charge_volt_drop <= 1'b0;
    end else begin
      int_out <= next_int;
      reset_out <= next_rst_out;
      charge_suspend <= next_susp;
      charge_half_current <= next_half;
      charge_volt_drop <= next_drop;
    end
  end

  assign temp_sense_enable = therm_reg[TFM_TEMP_EN_BIT];
  assign high_impedance_mode = fchg_reg[TFM_HIGH_IMP_BIT];
  assign fast_charge_ctrl_out = fchg_reg;
  assign fault_deglitched = flt;
endmodule

// ---- inc/tfm_pkg.sv ----
/*
  Constants for the thermal control, fault mask and fast-charge register bank.
  Assumes one 100 MHz clock and an I2C host reaching the registers.
*/
// Functional notes
// - Thermal bit 7 is writable, resets to 1, enables temperature sensing.
// - Bits 6:5 report the zone: 00 normal, 01 suspended, 10 current halved.
// - Zone 11 is the warm-to-hot band, regulation voltage lowered 140 mV.
// - Bit 3, reset 1: interrupt shows faults and charge status; 0 faults only.
// - Bit 2, reset 0: set suppresses the push-button wake interrupt.
// - Bit 1, reset 0: set suppresses push-button reset interrupt, not reset output.
// - Bit 0, reset 0: set suppresses the safety timer fault interrupt.
// - High-impedance mode stops the fault deglitch clock to save power.
// - Fault clears only while deglitch runs: battery with I2C busy, or supply present.
// - Fast-charge register at 0x03 is 8-bit read/write, resets to 1000 0000.
package tfm_pkg;
  // Register offsets
  localparam logic [7:0] TFM_THERM_OFS = 8'h02;
  localparam logic [7:0] TFM_FCHG_OFS = 8'h03;
  // Reset values
  localparam logic [7:0] TFM_THERM_RST = 8'h88;
  localparam logic [7:0] TFM_FCHG_RST = 8'h80;
  // Thermal register fields
  localparam int TFM_TEMP_EN_BIT = 7;
  localparam int TFM_ZONE_HI_BIT = 6;
  localparam int TFM_ZONE_LO_BIT = 5;
  localparam int TFM_INT_EN_BIT = 3;
  localparam int TFM_WAKE_M_BIT = 2;
  localparam int TFM_RESET_M_BIT = 1;
  localparam int TFM_TIMER_M_BIT = 0;
  // Writable bits of the thermal register
  localparam logic [7:0] TFM_THERM_WMASK = 8'h8F;
  // Fast-charge register: high-impedance mode bit
  localparam int TFM_HIGH_IMP_BIT = 0;
  // Zone codes
  localparam logic [1:0] TFM_ZONE_NORMAL = 2'h0;
  localparam logic [1:0] TFM_ZONE_SUSPEND = 2'h1;
  localparam logic [1:0] TFM_ZONE_HALF = 2'h2;
  localparam logic [1:0] TFM_ZONE_WARM = 2'h3;
  // Voltage drop in the warm band, millivolts
  localparam int TFM_WARM_DROP_MV = 140;
  // Synchronised input vector width
  localparam int TFM_NSYNC = 12;
  // Synchroniser reset: bus pins idle high, so no false edge after reset
  localparam logic [TFM_NSYNC-1:0] TFM_SYNC_RST = 12'h003;
  // I2C engine states
  typedef enum logic [2:0] {
    TFM_IDLE, TFM_ADDR, TFM_PTR, TFM_WDATA, TFM_ACK, TFM_READ, TFM_MACK
  } tfm_state_t;
endpackage

// ---- dv/tfm_regs_sva.sv ----
/*
  Port checker for the thermal mask register bank.
  Assumes it is bound onto tfm_regs, one clock, async reset.
*/
`timescale 1ns/100ps
module tfm_regs_sva (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Event inputs
  input wire logic [1:0] temp_zone_in,
  input wire logic fault_raw,
  input wire logic push_button_in,
  input wire logic other_fault,
  // Outputs
  input wire logic temp_sense_enable,
  input wire logic charge_suspend,
  input wire logic charge_half_current,
  input wire logic charge_volt_drop,
  input wire logic high_impedance_mode,
  input wire logic deglitch_clk_en,
  input wire logic fault_deglitched,
  input wire logic reset_out,
  input wire logic int_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Four cycles cover the sync and output flops
  sequence zone_held(logic [1:0] z);
    (temp_sense_enable && temp_zone_in == z) [*4];
  endsequence
  a_zone_cold_suspend: assert property (zone_held(2'h1) |-> charge_suspend)
    else $error("zone 01 without suspend");
  a_zone_cool_half: assert property (zone_held(2'h2) |-> charge_half_current)
    else $error("zone 10 without half current");
  a_zone_warm_drop: assert property (zone_held(2'h3) |-> charge_volt_drop)
    else $error("zone 11 without voltage drop");
  a_reset_out_follow: assert property (push_button_in [*4] |-> reset_out)
    else $error("reset output missing");
  a_fault_int_always: assert property (other_fault [*4] |-> int_out)
    else $error("fault interrupt missing");
  a_fault_set_quick: assert property (fault_raw [*4] |-> fault_deglitched)
    else $error("fault not latched");
  a_deglitch_clk_gate: assert property (deglitch_clk_en == !high_impedance_mode)
    else $error("deglitch clock not gated");
  // First sample of the mode bit proves the clock was stopped over the cycle
  a_stopped_fault_hold: assert property (high_impedance_mode && fault_deglitched
    ##1 high_impedance_mode |-> fault_deglitched)
    else $error("fault cleared with clock stopped");
endmodule
////////////////////////////////////////////////////////////////////////////
bind tfm_regs tfm_regs_sva u_sva (.sys_clk, .reset_n, .temp_zone_in, .fault_raw,
  .push_button_in, .other_fault, .temp_sense_enable, .charge_suspend,
  .charge_half_current, .charge_volt_drop, .high_impedance_mode, .deglitch_clk_en,
  .fault_deglitched, .reset_out, .int_out);

// ---- dv/tfm_i2c_host.sv ----
/*
  I2C host model for the register bank.
  Assumes the bench resolves sda as open drain with a pull-up.
*/
`timescale 1ns/100ps
module tfm_i2c_host #(
  parameter logic [6:0] DEV_ADDR = 7'h2A
) (
  // Clock
  input wire logic sys_clk,
  // Bus pins
  output logic scl,
  output logic sda_lo,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_lo = 1'b0;
  end
  // Six cycles a phase, three phases a bit, above the four-cycle minimum
  task automatic hp;
    repeat (6) @(negedge sys_clk);
  endtask
  task automatic bt(input logic b, output logic r);
    sda_lo = !b;
    hp;
    scl = 1'b1;
    hp;
    r = sda;
    scl = 1'b0;
    hp;
  endtask
  task automatic start;
    sda_lo = 1'b0;
    hp;
    scl = 1'b1;
    hp;
    sda_lo = 1'b1;
    hp;
    scl = 1'b0;
    hp;
  endtask
  task automatic stop;
    sda_lo = 1'b1;
    hp;
    scl = 1'b1;
    hp;
    sda_lo = 1'b0;
    hp;
  endtask
  task automatic by(input logic [7:0] d, input logic a, output logic [7:0] q, output logic n);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bt(d[i], r);
      q[i] = r;
    end
    bt(a, n);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                    output logic nak);
    logic [7:0] x;
    logic n0, n1, n2;
    start;
    by({a, 1'b0}, 1'b1, x, n0);
    by(p, 1'b1, x, n1);
    by(d, 1'b1, x, n2);
    stop;
    nak = n0 | n1 | n2;
  endtask
  // Bus activity also runs the deglitch on battery alone
  task automatic rd(input logic [7:0] p, output logic [7:0] q, output logic nak);
    logic [7:0] x;
    logic n0, n1, n2, n3;
    start;
    by({DEV_ADDR, 1'b0}, 1'b1, x, n0);
    by(p, 1'b1, x, n1);
    start;
    by({DEV_ADDR, 1'b1}, 1'b1, x, n2);
    by(8'hFF, 1'b1, q, n3);
    stop;
    nak = n0 | n1 | n2;
  endtask
endmodule

// ---- dv/tfm_regs_test.sv ----
/*
  Self-checking bench for the thermal mask register bank.
  Assumes the I2C host model drives the bus pins.
*/
`timescale 1ns/100ps
module tfm_regs_test;
  localparam int DG = 8;
  logic sys_clk, reset_n, scl, h_lo, sda_out, sda_oe, nak;
  logic [1:0] temp_zone_in;
  logic input_supply, battery_powered_mode, fault_raw, wake_event, push_button_in;
  logic timer_fault, other_fault, charge_status, temp_sense_enable, charge_suspend;
  logic charge_half_current, charge_volt_drop, high_impedance_mode, deglitch_clk_en;
  logic fault_deglitched, reset_out, int_out;
  logic [7:0] fc, q, d;
  wire sda = !(h_lo || (sda_oe && !sda_out));
  int miscompares, checked;
  tfm_regs #(.DEV_ADDR(7'h2A), .DEGLITCH_CYCLES(DG)) u_dut (.sys_clk, .reset_n,
    .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe, .temp_zone_in, .input_supply,
    .battery_powered_mode, .fault_raw, .wake_event, .push_button_in, .timer_fault,
    .other_fault, .charge_status, .temp_sense_enable, .charge_suspend,
    .charge_half_current, .charge_volt_drop, .high_impedance_mode,
    .fast_charge_ctrl_out(fc), .deglitch_clk_en, .fault_deglitched, .reset_out, .int_out);
  tfm_i2c_host #(.DEV_ADDR(7'h2A)) u_host (.sys_clk, .scl, .sda_lo(h_lo), .sda);
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("miscompares %0d checked %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  function automatic logic [7:0] exp_therm(logic [7:0] w, logic [1:0] z);
    return {w[7], w[7] ? z : 2'h0, 1'b0, w[3:0]};
  endfunction
  // Event order matches mask bits: charge, wake, button, timer
  function automatic logic exp_int(logic [3:0] m, logic [3:0] e);
    return |(e & {m[3], ~m[2:0]});
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #600000;
    miscompares++;
    final_report;
  end
  initial begin
    {reset_n, temp_zone_in, input_supply, battery_powered_mode, fault_raw} = '0;
    {wake_event, push_button_in, timer_fault, other_fault, charge_status} = '0;
    void'($urandom(25));
    wt(4);
    reset_n = 1'b1;
    wt(4);
    u_host.rd(8'h02, q, nak);
    check(q, 8'h88);
    u_host.rd(8'h03, q, nak);
    check(q, 8'h80);
    for (int i = 0; i < 6; i++) begin
      // Corner cases first: sensing off, then every zone with sensing on
      d = (i == 0) ? 8'h7F : (i < 5) ? {1'b1, 7'($urandom)} : 8'($urandom);
      temp_zone_in = (i == 0) ? 2'h3 : (i < 5) ? 2'(i - 1) : 2'($urandom);
      u_host.wr(7'h2A, 8'h02, d, nak);
      wt(5);
      check({charge_suspend, charge_half_current}, {d[7] && temp_zone_in == 2'h1,
        d[7] && temp_zone_in == 2'h2});
      check(charge_volt_drop, d[7] && temp_zone_in == 2'h3);
      u_host.rd(8'h02, q, nak);
      check(q, exp_therm(d, temp_zone_in));
      d = 8'($urandom);
      u_host.wr(7'h2A, 8'h03, d, nak);
      u_host.rd(8'h03, q, nak);
      check(q, d);
      check(nak, 1'b0);
      check(fc, d);
      check({high_impedance_mode, deglitch_clk_en}, {d[0], !d[0]});
    end
    u_host.wr(7'h2A, 8'h05, 8'hA5, nak);
    u_host.rd(8'h05, q, nak);
    check(q, 8'h00);
    for (int m = 0; m < 16; m++) begin
      u_host.wr(7'h2A, 8'h02, {4'h8, 4'(m)}, nak);
      for (int e = 0; e < 4; e++) begin
        {charge_status, wake_event, push_button_in, timer_fault} = 4'h1 << e;
        wt(5);
        check(int_out, exp_int(4'(m), 4'h1 << e));
        check(reset_out, push_button_in);
      end
      {charge_status, wake_event, push_button_in, timer_fault} = 4'h0;
      u_host.rd(8'h02, q, nak);
      check(q, exp_therm({4'h8, 4'(m)}, temp_zone_in));
    end
    u_host.wr(7'h2A, 8'h03, 8'h80, nak);
    input_supply = 1'b1;
    fault_raw = 1'b1;
    wt(5);
    fault_raw = 1'b0;
    wt(5);
    check(fault_deglitched, 1'b1);
    wt(DG + 8);
    check(fault_deglitched, 1'b0);
    u_host.wr(7'h2A, 8'h03, 8'h81, nak);
    fault_raw = 1'b1;
    wt(5);
    fault_raw = 1'b0;
    wt(40);
    check(fault_deglitched, 1'b1);
    input_supply = 1'b0;
    u_host.wr(7'h2A, 8'h03, 8'h80, nak);
    battery_powered_mode = 1'b1;
    wt(40);
    check(fault_deglitched, 1'b1);
    u_host.rd(8'h03, q, nak);
    check(fault_deglitched, 1'b0);
    u_host.wr(7'h2B, 8'h02, 8'h00, nak);
    check({nak, temp_sense_enable}, 2'h3);
    other_fault = 1'b1;
    wt(5);
    check(int_out, 1'b1);
    final_report;
  end
endmodule
